// ===== src/ppd_instr.sv
// instruction layer of the program/debug port: cs space, repeat, keys, info block
`timescale 1ns/1ps
`default_nettype none

module ppd_instr #(
   parameter logic [7:0]  RESET_SIG   = 8'h59,
   parameter logic [55:0] FAMILY_CODE = 56'h30_5f44_5050_5858,   // arbitrary
   parameter logic [23:0] NVM_REV     = 24'h31_3a_50,            // arbitrary
   parameter logic [23:0] DBG_REV     = 24'h31_3a_44,            // arbitrary
   parameter logic [7:0]  OSC_FREQ    = 8'h33                    // arbitrary
) (
   input  wire logic                          clk_i,
   input  wire logic                          arst_n_i,
   input  wire logic                          rx_valid_i,
   input  wire logic [7:0]                    rx_data_i,
   input  wire logic                          rx_break_i,
   input  wire logic                          baud_tick_i,
   output logic                               tx_valid_o,
   output logic [7:0]                         tx_data_o,
   input  wire logic                          tx_ready_i,
   output logic                               ext_start_o,
   output logic [7:0]                         ext_opcode_o,
   output logic [1:0]                         ext_ptr_step_o,
   input  wire logic                          ext_done_i,
   input  wire logic                          lock_i,
   input  wire logic                          prog_done_i,
   input  wire logic                          port_disable_i,
   output logic                               sys_reset_o,
   output logic                               chip_erase_o,
   output logic                               nvm_prog_o,
   output logic                               urow_prog_o,
   input  wire logic [ppd_pkg::AV_ADDR_W-1:0] avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [31:0]                   avs_writedata_i,
   input  wire logic [3:0]                    avs_byteenable_i,
   output logic [31:0]                        avs_readdata_o,
   output logic                               avs_waitrequest_o
);

   // ==========================================================
   // reset release
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ==========================================================
   // state and registers
   ppd_pkg::ppd_state_t state_q, state_d;
   logic [7:0]          opc_q, opc_d;
   logic [7:0]          rpt_q, rpt_d;
   logic [4:0]          cnt_q, cnt_d;
   logic [4:0]          left_q, left_d;
   logic [7:0]          gap_q, gap_d;
   logic [7:0]          txd_q, txd_d;
   logic [63:0]         key_q, key_d;
   logic [7:0]          ctrla_q;
   logic [7:0]          rstreq_q;
   logic [2:0]          pesig_q;
   logic                erase_q, nvm_q, urow_q;
   logic                sysrst_q, cherase_q;
   logic                ext_start_q;
   logic [1:0]          step_q, step_d;
   logic                rd_ack_q;
   logic [31:0]         rdata_q;
   ppd_pkg::ppd_cs_wr_t link_wr, wr;

   logic                done_op, launch, key_chk, pesig_set, cs_rd_stb, ext_go;
   logic [7:0]          l_opc;
   logic [2:0]          l_op;
   logic [127:0]        info_blk;
   logic [7:0]          cs_view [ppd_pkg::CS_DEPTH];

   // byte 0 first: family, reserved, nvm rev, debugger rev, reserved, osc
   assign info_blk = {OSC_FREQ, 8'h00, DBG_REV, NVM_REV, 8'h00, FAMILY_CODE};

   function automatic logic [7:0] info_byte(input logic [127:0] blk, input logic [4:0] idx);
      info_byte = blk[{idx[3:0], 3'b000} +: 8];
   endfunction

   // field 7 still leaves one idle bit
   function automatic logic [7:0] gt_bits(input logic [2:0] fld);
      gt_bits = ppd_pkg::GT_MAX >> fld;
   endfunction

   // ==========================================================
   // cs space view
   wire ib_dly_en = ctrla_q[ppd_pkg::CTRLA_IB_DLY];
   wire nvm_ok  = nvm_q && !lock_i && !sysrst_q;
   wire urow_ok = urow_q && lock_i && !sysrst_q;

   always_comb
   begin
      for (int i = 0; i < ppd_pkg::CS_DEPTH; i++)
         cs_view[i] = 8'h00;
      // physical layer at 0-3, access layer from 4, 15 reads zero
      cs_view[ppd_pkg::CS_STATUS_A]   = ppd_pkg::STATUSA_RST;
      cs_view[ppd_pkg::CS_STATUS_B]   = {5'h00, pesig_q};
      cs_view[ppd_pkg::CS_CTRL_A]     = ctrla_q;
      cs_view[ppd_pkg::CS_KEY_STATUS] = {2'b00, urow_q, nvm_q, erase_q, 3'b000};
      cs_view[ppd_pkg::CS_RESET_REQ]  = rstreq_q;
      cs_view[ppd_pkg::CS_SYS_STATUS] = {2'b00, sysrst_q, 1'b0, nvm_ok, urow_ok, 1'b0, lock_i};
   end

   // ==========================================================
   // bus slave
   wire        av_mapped = avs_address_i[ppd_pkg::AV_ADDR_W-1:6] == '0;
   wire [3:0]  av_idx    = avs_address_i[5:2];
   wire        av_rd_lat = avs_read_i && !rd_ack_q;
   wire        av_wr_ok  = avs_write_i && !link_wr.en;
   wire        av_pe_rd  = av_rd_lat && av_mapped && av_idx == ppd_pkg::CS_STATUS_B;

   // link writes win the single write port; a bus write waits every cycle a link write holds it
   assign avs_waitrequest_o = (avs_read_i && !rd_ack_q) || (avs_write_i && link_wr.en);
   assign avs_readdata_o    = rdata_q;
   assign wr = link_wr.en ? link_wr
             : ppd_pkg::ppd_cs_wr_t'{en:   av_wr_ok && av_mapped && avs_byteenable_i[0],
                 addr: av_idx,
                 data: avs_writedata_i[7:0]};

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ack_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end
      else
      begin
         rd_ack_q <= av_rd_lat;
         if (av_rd_lat)
            rdata_q <= av_mapped ? {24'h00_0000, cs_view[av_idx]} : 32'h0000_0000;
      end
   end

   // ==========================================================
   // instruction sequencer
   assign l_op = l_opc[ppd_pkg::OPC_HI:ppd_pkg::OPC_LO];

   always_comb
   begin
      state_d   = state_q;
      opc_d     = opc_q;
      rpt_d     = rpt_q;
      cnt_d     = cnt_q;
      left_d    = left_q;
      gap_d     = gap_q;
      txd_d     = txd_q;
      key_d     = key_q;
      step_d    = step_q;
      link_wr   = '0;
      done_op   = 1'b0;
      launch    = 1'b0;
      l_opc     = opc_q;
      key_chk   = 1'b0;
      pesig_set = 1'b0;
      cs_rd_stb = 1'b0;
      ext_go    = 1'b0;
      unique case (state_q)
         ppd_pkg::S_SYNC:
            if (rx_valid_i && rx_data_i == ppd_pkg::SYNC_CHAR)
               state_d = ppd_pkg::S_OPC;
         ppd_pkg::S_OPC:
            if (rx_valid_i)
            begin
               launch = 1'b1;
               l_opc  = rx_data_i;
            end
         ppd_pkg::S_CSDATA:
            if (rx_valid_i)
            begin
               link_wr = '{en: 1'b1, addr: opc_q[3:0], data: rx_data_i};
               done_op = 1'b1;
            end
         ppd_pkg::S_RPT:
            if (rx_valid_i)
            begin
               rpt_d   = rx_data_i;
               state_d = ppd_pkg::S_SYNC;
            end
         ppd_pkg::S_KEY:
            if (rx_valid_i)
            begin
               key_d = {rx_data_i, key_q[63:8]};
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == ppd_pkg::KEY_BYTES - 5'h01)
               begin
                  key_chk = 1'b1;
                  done_op = 1'b1;
               end
            end
         ppd_pkg::S_GAP:
            if (baud_tick_i)
            begin
               gap_d = gap_q - 8'h01;
               if (gap_q <= 8'h01)
                  state_d = ppd_pkg::S_TX;
            end
         ppd_pkg::S_TX:
            if (tx_ready_i)
            begin
               if (left_q <= 5'h01)
                  done_op = 1'b1;
               else
               begin
                  left_d = left_q - 5'h01;
                  cnt_d  = cnt_q + 5'h01;
                  txd_d  = info_byte(info_blk, cnt_q + 5'h01);
                  if (ib_dly_en)
                  begin
                     gap_d   = ppd_pkg::IB_EXTRA;
                     state_d = ppd_pkg::S_GAP;
                  end
               end
            end
         ppd_pkg::S_EXT:
            if (ext_done_i)
               done_op = 1'b1;
         default:
            state_d = ppd_pkg::S_SYNC;
      endcase

      // next iteration reuses the stored opcode, no sync or opcode frame
      if (done_op)
      begin
         if (rpt_q != 8'h00)
         begin
            rpt_d  = rpt_q - 8'h01;
            launch = 1'b1;
         end
         else
            state_d = ppd_pkg::S_SYNC;
      end

      if (launch)
      begin
         opc_d = l_opc;
         cnt_d = 5'h00;
         gap_d = gt_bits(ctrla_q[2:0]);
         unique case (l_op)
            ppd_pkg::OP_CS_LOAD:
            begin
               txd_d     = cs_view[l_opc[3:0]];
               cs_rd_stb = l_opc[3:0] == ppd_pkg::CS_STATUS_B;
               left_d    = 5'h01;
               state_d   = ppd_pkg::S_GAP;
            end
            ppd_pkg::OP_CS_STORE:
               state_d = ppd_pkg::S_CSDATA;
            ppd_pkg::OP_REPEAT:
            begin
               rpt_d   = 8'h00;
               state_d = ppd_pkg::S_RPT;
            end
            ppd_pkg::OP_KEY:
               if (l_opc[ppd_pkg::KEY_INFO_BIT])
               begin
                  left_d  = (l_opc[1:0] == ppd_pkg::KSZ_128) ? ppd_pkg::INFO_FULL : ppd_pkg::INFO_ID;
                  txd_d   = info_byte(info_blk, 5'h00);
                  state_d = ppd_pkg::S_GAP;
               end
               else if (l_opc[1:0] == ppd_pkg::KSZ_64)
                  state_d = ppd_pkg::S_KEY;
               else
               begin
                  rpt_d   = 8'h00;
                  state_d = ppd_pkg::S_SYNC;
               end
            default:
               if (lock_i)
               begin
                  pesig_set = 1'b1;
                  rpt_d     = 8'h00;
                  state_d   = ppd_pkg::S_SYNC;
               end
               else
               begin
                  ext_go  = 1'b1;
                  step_d  = (l_op == ppd_pkg::OP_IND_STORE && l_opc[ppd_pkg::PMODE_HI:ppd_pkg::PMODE_LO]
                             == ppd_pkg::PMODE_INC) ? l_opc[1:0] + 2'h1 : 2'h0;
                  state_d = ppd_pkg::S_EXT;
               end
         endcase
      end

      if (rx_break_i)
      begin
         state_d = ppd_pkg::S_SYNC;
         rpt_d   = 8'h00;
         ext_go  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q     <= ppd_pkg::S_SYNC;
         opc_q       <= 8'h00;
         rpt_q       <= 8'h00;
         cnt_q       <= 5'h00;
         left_q      <= 5'h00;
         gap_q       <= 8'h00;
         txd_q       <= 8'h00;
         key_q       <= 64'h0;
         step_q      <= 2'h0;
         ext_start_q <= 1'b0;
      end
      else
      begin
         state_q     <= state_d;
         opc_q       <= opc_d;
         rpt_q       <= rpt_d;
         cnt_q       <= cnt_d;
         left_q      <= left_d;
         gap_q       <= gap_d;
         txd_q       <= txd_d;
         key_q       <= key_d;
         step_q      <= step_d;
         ext_start_q <= ext_go;
      end
   end

   assign tx_valid_o     = state_q == ppd_pkg::S_TX;
   assign tx_data_o      = txd_q;
   assign ext_start_o    = ext_start_q;
   assign ext_opcode_o   = opc_q;
   assign ext_ptr_step_o = step_q;

   // ==========================================================
   // cs registers and key state
   wire match_erase = key_chk && key_d == ppd_pkg::KEY_ERASE;
   wire match_nvm   = key_chk && key_d == ppd_pkg::KEY_NVM;
   wire match_urow  = key_chk && key_d == ppd_pkg::KEY_UROW;
   wire wr_ctrla    = wr.en && wr.addr == ppd_pkg::CS_CTRL_A;
   wire wr_rstreq   = wr.en && wr.addr == ppd_pkg::CS_RESET_REQ;
   wire wr_urow_clr = wr.en && wr.addr == ppd_pkg::CS_KEY_STATUS && wr.data[ppd_pkg::KS_UROW];
   wire [7:0] rstreq_d = wr_rstreq ? wr.data : rstreq_q;
   wire       pe_clr   = cs_rd_stb || av_pe_rd;

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrla_q   <= ppd_pkg::CTRLA_RST;
         rstreq_q  <= 8'h00;
         pesig_q   <= 3'h0;
         erase_q   <= 1'b0;
         nvm_q     <= 1'b0;
         urow_q    <= 1'b0;
         sysrst_q  <= 1'b0;
         cherase_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrla)
            ctrla_q <= wr.data;
         rstreq_q  <= rstreq_d;
         // an error seen in the read cycle survives the clear
         pesig_q   <= pesig_set ? ppd_pkg::PESIG_LOCKED : (pe_clr ? 3'h0 : pesig_q);
         erase_q   <= match_erase || (erase_q && !port_disable_i);
         nvm_q     <= match_nvm || (nvm_q && !prog_done_i);
         urow_q    <= match_urow || (urow_q && !wr_urow_clr);
         sysrst_q  <= rstreq_d == RESET_SIG;
         cherase_q <= erase_q && rstreq_q == RESET_SIG && rstreq_d == 8'h00;
      end
   end

   assign sys_reset_o  = sysrst_q;
   assign chip_erase_o = cherase_q;
   assign nvm_prog_o   = nvm_ok;
   assign urow_prog_o  = urow_ok;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n);

   AST_CS_STORE_SILENT: assert property (
      (state_q == ppd_pkg::S_CSDATA && rx_valid_i && !rx_break_i && rpt_q == 8'h00)
      |=> !tx_valid_o [*3])
      else $error("reply seen after cs_store");

   AST_GUARD_FIRST: assert property (
      $rose(tx_valid_o) |-> $past(state_q) == ppd_pkg::S_GAP && $past(baud_tick_i))
      else $error("transmit started without guard idle");

   AST_REPEAT_DEC: assert property (
      (done_op && rpt_q != 8'h00 && !rx_break_i) |=> rpt_q == $past(rpt_q) - 8'h01)
      else $error("repeat count did not step down by one");

   AST_REPEAT_NO_SYNC: assert property (
      (done_op && rpt_q != 8'h00 && !rx_break_i) |=> state_q != ppd_pkg::S_SYNC && state_q != ppd_pkg::S_OPC)
      else $error("repeat iteration waited for sync");

   AST_BREAK_ABORT: assert property (
      rx_break_i |=> state_q == ppd_pkg::S_SYNC && rpt_q == 8'h00)
      else $error("break did not abort sequence");

   AST_REPEAT_SELF: assert property (
      (state_q == ppd_pkg::S_RPT && rx_valid_i && !rx_break_i) |=> state_q == ppd_pkg::S_SYNC)
      else $error("repeat instruction was repeated");

   AST_KEY_ERASE: assert property (
      (key_chk && key_d == ppd_pkg::KEY_ERASE) |=> erase_q)
      else $error("erase key not activated");

   AST_BAD_KEY: assert property (
      (key_chk && key_d != ppd_pkg::KEY_ERASE && key_d != ppd_pkg::KEY_NVM && key_d != ppd_pkg::KEY_UROW
       && !port_disable_i && !prog_done_i && !wr_urow_clr)
      |=> $stable({erase_q, nvm_q, urow_q}))
      else $error("bad key changed key flags");

   AST_LOCK_REFUSE: assert property (
      ext_start_o |-> $past(!lock_i))
      else $error("system access started while locked");

   AST_IB_DELAY_GAP: assert property (
      (tx_valid_o && tx_ready_i && left_q > 5'h01 && ib_dly_en && !rx_break_i)
      |=> state_q == ppd_pkg::S_GAP && gap_q == ppd_pkg::IB_EXTRA)
      else $error("interbyte delay missing");

   AST_NVM_HOLD: assert property (
      (nvm_q && !prog_done_i) |=> nvm_q)
      else $error("program key lost without programming done");

endmodule

`default_nettype wire

// ===== shared/ppd_pkg.sv
// constants, types and field layout for the program/debug port instruction layer
package ppd_pkg;

   // ==========================================================
   // link characters and opcode layout
   localparam logic [7:0] SYNC_CHAR    = 8'h55;
   localparam int         OPC_HI       = 7;
   localparam int         OPC_LO       = 5;
   localparam logic [2:0] OP_IND_STORE = 3'h3;
   localparam logic [2:0] OP_CS_LOAD   = 3'h4;
   localparam logic [2:0] OP_REPEAT    = 3'h5;
   localparam logic [2:0] OP_CS_STORE  = 3'h6;
   localparam logic [2:0] OP_KEY       = 3'h7;
   localparam int         KEY_INFO_BIT = 2;
   localparam logic [1:0] KSZ_64       = 2'h0;
   localparam logic [1:0] KSZ_128      = 2'h1;
   localparam int         PMODE_HI     = 3;
   localparam int         PMODE_LO     = 2;
   localparam logic [1:0] PMODE_INC    = 2'h1;

   // ==========================================================
   // control/status space
   localparam logic [3:0] CS_STATUS_A   = 4'h0;
   localparam logic [3:0] CS_STATUS_B   = 4'h1;
   localparam logic [3:0] CS_CTRL_A     = 4'h2;
   localparam logic [3:0] CS_CTRL_B     = 4'h3;
   localparam logic [3:0] CS_ASI_FIRST  = 4'h4;
   localparam logic [3:0] CS_KEY_STATUS = 4'h7;
   localparam logic [3:0] CS_RESET_REQ  = 4'h8;
   localparam logic [3:0] CS_SYS_STATUS = 4'hb;
   localparam logic [3:0] CS_RESERVED   = 4'hf;
   localparam int         CS_DEPTH      = 16;
   localparam int         CTRLA_IB_DLY  = 7;
   localparam int         KS_UROW       = 5;
   localparam int         KS_NVM        = 4;
   localparam int         KS_ERASE      = 3;
   localparam int         SS_LOCK       = 0;
   localparam int         SS_UROWPROG   = 2;
   localparam int         SS_NVM_OK     = 3;
   localparam int         SS_RSTSYS     = 5;
   localparam logic [7:0] STATUSA_RST   = 8'h10;
   localparam logic [7:0] CTRLA_RST     = 8'h00;
   localparam logic [2:0] PESIG_LOCKED  = 3'h3;

   // ==========================================================
   // keys, readout sizes and timing
   localparam logic [63:0] KEY_ERASE  = 64'h4e564d4572617365;
   localparam logic [63:0] KEY_NVM    = 64'h4e564d50726f6720;
   localparam logic [63:0] KEY_UROW   = 64'h4e564d5573267465;
   localparam logic [4:0]  KEY_BYTES  = 5'h08;
   localparam logic [4:0]  INFO_FULL  = 5'h10;
   localparam logic [4:0]  INFO_ID    = 5'h08;
   localparam logic [7:0]  IB_EXTRA   = 8'h02;
   localparam logic [7:0]  GT_MAX     = 8'h80;
   localparam int          AV_ADDR_W  = 8;

   typedef struct packed {
      logic       en;
      logic [3:0] addr;
      logic [7:0] data;
   } ppd_cs_wr_t;

   typedef enum logic [7:0] {
      S_SYNC   = 8'h01,
      S_OPC    = 8'h02,
      S_CSDATA = 8'h04,
      S_RPT    = 8'h08,
      S_KEY    = 8'h10,
      S_GAP    = 8'h20,
      S_TX     = 8'h40,
      S_EXT    = 8'h80
   } ppd_state_t;

endpackage

// ===== bench/ppd_dbg_model.sv
// debugger-side model: bit ticks, stamped byte capture, memory engine stub
`timescale 1ns/1ps
`default_nettype none
module ppd_dbg_model (
   input  wire logic       clk_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       ext_start_i,
   output logic            baud_tick_o,
   output logic            tx_ready_o,
   output logic            ext_done_o
);
   logic [2:0] div_q = 3'h0;
   logic [2:0] eng_q = 3'h0;
   int         cyc   = 0;
   int         n_ext = 0;
   logic [7:0] d_q[$];
   int         t_q[$];
   // a byte leaves only on a bit boundary, so gaps are counted in whole bits
   assign baud_tick_o = (div_q == 3'h7);
   assign tx_ready_o  = tx_valid_i & baud_tick_o;
   assign ext_done_o  = (eng_q == 3'h1); // next frame, address resent, only after the ack
   always @(posedge clk_i)
   begin
      cyc   <= cyc + 1;
      div_q <= div_q + 3'h1;
      eng_q <= ext_start_i ? 3'h4 : eng_q - 3'(eng_q != 3'h0);
      if (tx_ready_o)
      begin
         d_q.push_back(tx_data_i);
         t_q.push_back(cyc);
      end
      if (ext_start_i)
         n_ext <= n_ext + 1;
   end
endmodule
`default_nettype wire

// ===== bench/ppd_instr_tb.sv
// self-checking bench for the program/debug port instruction layer
`timescale 1ns/1ps
`default_nettype none
module ppd_instr_tb;
   // ==========================================================
   // stimulus and hookup
   localparam logic [55:0] FAM  = 56'h37_36_35_34_33_32_31; // arbitrary
   localparam logic [23:0] NVR  = 24'h41_42_43;             // arbitrary
   localparam logic [23:0] DBR  = 24'h44_45_46;             // arbitrary
   localparam logic [7:0]  OSC  = 8'h47;                    // arbitrary
   localparam logic [7:0]  RSIG = 8'h59;
   localparam logic [7:0]  SY   = ppd_pkg::SYNC_CHAR;
   logic        clk_i = 1'b0, arst_n = 1'b0, rx_v = 1'b0, brk = 1'b0, lock = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [7:0]  rx_d = 8'h00, adr = 8'h00, q, txd, xop;
   logic [31:0] wd = 32'h0, rdata;
   logic        tick, txv, txr, xs, xd, wq, sysr, ce, nvmp, urp, pdis = 1'b0, erased = 1'b0;
   logic [1:0]  xstep;
   int          fail_count = 0, n_compared = 0, tmo = 0, t0, k;
   ppd_instr #(.RESET_SIG(RSIG), .FAMILY_CODE(FAM), .NVM_REV(NVR), .DBG_REV(DBR), .OSC_FREQ(OSC)) u_ppd_instr (
      .clk_i(clk_i), .arst_n_i(arst_n), .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_break_i(brk),
      .baud_tick_i(tick), .tx_valid_o(txv), .tx_data_o(txd), .tx_ready_i(txr), .ext_start_o(xs),
      .ext_opcode_o(xop), .ext_ptr_step_o(xstep), .ext_done_i(xd), .lock_i(lock), .prog_done_i(1'b0),
      .port_disable_i(pdis), .sys_reset_o(sysr), .chip_erase_o(ce), .nvm_prog_o(nvmp), .urow_prog_o(urp),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'h1), .avs_readdata_o(rdata), .avs_waitrequest_o(wq));
   ppd_dbg_model u_ppd_dbg_model (.clk_i(clk_i), .tx_valid_i(txv), .tx_data_i(txd), .ext_start_i(xs),
      .baud_tick_o(tick), .tx_ready_o(txr), .ext_done_o(xd));
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      erased <= erased | ce;
      tmo <= tmo + 1;
      if (tmo == 40000)
      begin
         fail_count = fail_count + 1;
         tally_and_finish();
      end
   end
   // ==========================================================
   // shared tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      n_compared = n_compared + 1;
      if (s !== e)
      begin
         $display("unexpected %s expected %h seen %h", n, e, s);
         fail_count = fail_count + 1;
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      rd  <= ~w;
      wr  <= w;
      adr <= a;
      wd  <= {24'h0, d};
      do
         @(posedge clk_i);
      while (wq !== 1'b0);
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rxs(input logic [7:0] b[$]);
      foreach (b[i])
      begin
         @(posedge clk_i);
         rx_v <= 1'b1;
         rx_d <= b[i];
         @(posedge clk_i);
         rx_v <= 1'b0;
      end
   endtask
   task automatic key(input logic [63:0] v);
      rxs('{SY, 8'he0, v[7:0], v[15:8], v[23:16], v[31:24], v[39:32], v[47:40], v[55:48], v[63:56]});
      bus(1'b0, 8'h1c, 8'h00);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      bus(1'b0, 8'h00, 8'h00);
      chk("status_a", ppd_pkg::STATUSA_RST, q);
      bus(1'b1, 8'h3c, 8'hff);
      bus(1'b0, 8'h3c, 8'h00);
      chk("reserved", 8'h00, q);
      bus(1'b0, 8'h40, 8'h00);
      chk("unmapped", 8'h00, q);
   endtask
   task automatic t_cs();
      rxs('{SY, 8'h80});
      t0 = u_ppd_dbg_model.cyc;
      while (u_ppd_dbg_model.d_q.size() < 1)
         @(posedge clk_i);
      chk("cs_load", ppd_pkg::STATUSA_RST, u_ppd_dbg_model.d_q[0]);
      chk("guard", 8'h01, 8'(u_ppd_dbg_model.t_q[0] - t0 >= 1016));
      u_ppd_dbg_model.d_q.delete();
      u_ppd_dbg_model.t_q.delete();
      rxs('{SY, 8'hc2, 8'h87});
      repeat (200) @(posedge clk_i);
      chk("no_reply", 8'h00, 8'(u_ppd_dbg_model.d_q.size()));
      bus(1'b0, 8'h08, 8'h00);
      chk("ctrl", 8'h87, q);
   endtask
   task automatic t_info();
      logic [127:0] e;
      e = {OSC, 8'h00, DBR, NVR, 8'h00, FAM};
      rxs('{SY, 8'he5});
      t0 = u_ppd_dbg_model.cyc;
      while (u_ppd_dbg_model.d_q.size() < 16)
         @(posedge clk_i);
      chk("first_gap", 8'h01, 8'(u_ppd_dbg_model.t_q[0] - t0 < 20));
      for (k = 0; k < 16; k++)
      begin
         if (k != 7 && k != 14)
            chk("info", e[8*k +: 8], u_ppd_dbg_model.d_q[k]);
         if (k > 0)
            chk("ib_gap", 8'h01, 8'(u_ppd_dbg_model.t_q[k] - u_ppd_dbg_model.t_q[k-1] >= 16));
      end
   endtask
   task automatic t_key();
      key(ppd_pkg::KEY_NVM);
      key(ppd_pkg::KEY_ERASE ^ 64'h1);
      chk("bad_key", 8'h10, q);
      key(ppd_pkg::KEY_ERASE);
      chk("keys", 8'h18, q);
      bus(1'b1, 8'h20, RSIG);
      @(posedge clk_i);
      chk("sys_reset", 8'h01, {7'h0, sysr});
      bus(1'b1, 8'h20, 8'h00);
      repeat (4) @(posedge clk_i);
      chk("erase", 8'h01, {7'h0, erased});
      chk("sys_reset_clr", 8'h00, {7'h0, sysr});
      chk("nvm_prog", 8'h01, {7'h0, nvmp});
      chk("key_silent", 8'h10, 8'(u_ppd_dbg_model.d_q.size()));
      pdis <= 1'b1;
      @(posedge clk_i);
      pdis <= 1'b0;
      bus(1'b0, 8'h1c, 8'h00);
      chk("erase_clr", 8'h10, q);
   endtask
   task automatic t_rpt();
      k = u_ppd_dbg_model.n_ext;
      rxs('{SY, 8'ha0, 8'h02, SY, 8'h64});
      repeat (60) @(posedge clk_i);
      chk("runs", 8'h03, 8'(u_ppd_dbg_model.n_ext - k));
      chk("ptr_step", 8'h01, {6'h0, xstep});
      chk("opcode", 8'h64, xop);
      k = u_ppd_dbg_model.n_ext;
      rxs('{SY, 8'ha0, 8'h05, SY, 8'h64});
      brk <= 1'b1;
      @(posedge clk_i);
      brk <= 1'b0;
      repeat (80) @(posedge clk_i);
      chk("break", 8'h01, 8'(u_ppd_dbg_model.n_ext - k < 6));
      lock <= 1'b1;
      k = u_ppd_dbg_model.n_ext;
      rxs('{SY, 8'h64});
      repeat (20) @(posedge clk_i);
      chk("locked", 8'h00, 8'(u_ppd_dbg_model.n_ext - k));
      bus(1'b0, 8'h04, 8'h00);
      chk("err", 8'h03, q);
      key(ppd_pkg::KEY_UROW);
      chk("urow_key", 8'h30, q);
      chk("urow_prog", 8'h01, {7'h0, urp});
      chk("nvm_locked", 8'h00, {7'h0, nvmp});
      bus(1'b1, 8'h1c, 8'h20);
      @(posedge clk_i);
      chk("urow_clr", 8'h00, {7'h0, urp});
      rxs('{SY, 8'he4});
      while (u_ppd_dbg_model.d_q.size() < 24)
         @(posedge clk_i);
      repeat (100) @(posedge clk_i);
      chk("info_len", 8'h18, 8'(u_ppd_dbg_model.d_q.size()));
      chk("info_locked", FAM[7:0], u_ppd_dbg_model.d_q[16]);
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_regs();
      t_cs();
      t_info();
      t_key();
      t_rpt();
      tally_and_finish();
   end
endmodule
`default_nettype wire
